// [core/sddt_map.vh]
// register offsets, field positions, reset values and timing counts of the drain delay timers
// assumes inclusion by the single design file of the block
`ifndef SDDT_MAP_VH
`define SDDT_MAP_VH
`define SDDT_OFF_STK2       12'h018
`define SDDT_OFF_STK3       12'h01c
`define SDDT_OFF_RDRAIN     12'h080
`define SDDT_OFF_MCDRAIN    12'h084
`define SDDT_OFF_INTSTS     12'h090
`define SDDT_OFF_INTMSK     12'h094
`define SDDT_OFF_STATE      12'h098
`define SDDT_STK_MSB        4
`define SDDT_DLY_MSB        15
`define SDDT_RDRAIN_RST     16'h00fa
`define SDDT_MCDRAIN_RST    16'h03e8
`define SDDT_CLK_MHZ        25
`define SDDT_TICK_US        1
`define SDDT_TICK_CYC       (`SDDT_CLK_MHZ * `SDDT_TICK_US)
`define SDDT_INT_RDONE      0
`define SDDT_INT_MSTART     1
`define SDDT_INT_MDONE      2
`endif

// [core/sddt_top.v]
// drain delay timers and stack configuration registers of a packet switch, APB slave
// assumes one 25 MHz clock, synchronous active low reset, inputs synchronous to the clock
`timescale 1ns/10ps
`include "sddt_map.vh"

// Operation
// - stack two config field, 5 bits, read-write, reset value from its straps
// - stack three config field, 5 bits, read-write, reset value from its straps
// - 16-bit reset drain delay in microseconds held for reset events
// - reset drain delay defaults to 250 microseconds
// - 16-bit mode change drain delay in microseconds held
// - at least the mode change delay elapses between started and done flags
// - mode change drain delay defaults to one millisecond
module sddt_top (
    // clock and reset
    input  wire        CLOCK,
    input  wire        RST_B,
    // apb slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    // configuration straps
    input  wire [4:0]  STACK_TWO_CONFIG_STRAPS,
    input  wire [4:0]  STACK_THREE_CONFIG_STRAPS,
    // stack layout selects to the port stacks
    output wire [4:0]  STACK_TWO_LAYOUT_SELECT,
    output wire [4:0]  STACK_THREE_LAYOUT_SELECT,
    // reset drain handshake with the reset controller
    input  wire        RESET_DRAIN_START,
    output wire        RESET_DRAIN_BUSY,
    output reg         RESET_DRAIN_DONE,
    // operating mode change handshake with the port logic
    input  wire        MODE_CHANGE_REQ,
    output reg         MODE_CHANGE_STARTED_FLAG,
    output reg         MODE_CHANGE_DONE_FLAG,
    // interrupt
    output wire        IRQ
);

    // drain timer states
    localparam ST_IDLE  = 1'b0;
    localparam ST_DRAIN = 1'b1;

    // last divider count of one microsecond
    localparam [31:0] TICK_LAST_W = `SDDT_TICK_CYC - 1;
    localparam [4:0]  TICK_LAST   = TICK_LAST_W[4:0];

    // configuration and delay registers
    reg  [4:0]  stk2_q;
    reg  [4:0]  stk3_q;
    reg  [15:0] rdrain_q;
    reg  [15:0] mdrain_q;
    reg  [2:0]  int_sts_q;
    reg  [2:0]  int_msk_q;
    reg         strap_load_q;
    reg  [4:0]  div_q;
    reg         tick_q;
    reg         r_st_q;
    reg  [16:0] r_cnt_q;
    reg         m_st_q;
    reg  [16:0] m_cnt_q;
    reg  [2:0]  ev_d;
    reg  [31:0] rdata_d;
    wire        wr_en;
    wire        rd_en;
    wire        r_end;
    wire        m_end;
    wire        sel_stk2;
    wire        sel_stk3;
    wire        sel_rdrain;
    wire        sel_mdrain;
    wire        sel_ists;
    wire        sel_imsk;
    wire        ev_rdone;
    wire        ev_mstart;
    wire        ev_mdone;
    wire [2:0]  sts_clr;

    // the first tick after a start is partial, so one extra tick is counted;
    // this keeps every drain at least the programmed number of microseconds
    function delay_ended;
        input        st;
        input [16:0] cnt;
        input [15:0] lim;
        begin
            if (lim == 16'h0000) begin
                delay_ended = st;
            end else begin
                delay_ended = st && (cnt > {1'b0, lim});
            end
        end
    endfunction

    // register decode on the byte address
    function addr_hit;
        input [11:0] addr;
        input [11:0] offs;
        begin
            addr_hit = (addr == offs);
        end
    endfunction

    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PWRITE;

    // one select per writable register, used by the stack and status write paths only
    assign sel_stk2   = addr_hit(PADDR, `SDDT_OFF_STK2);
    assign sel_stk3   = addr_hit(PADDR, `SDDT_OFF_STK3);
    assign sel_rdrain = addr_hit(PADDR, `SDDT_OFF_RDRAIN);
    assign sel_mdrain = addr_hit(PADDR, `SDDT_OFF_MCDRAIN);
    assign sel_ists   = addr_hit(PADDR, `SDDT_OFF_INTSTS);
    assign sel_imsk   = addr_hit(PADDR, `SDDT_OFF_INTMSK);

    // microsecond tick divider
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            div_q  <= 5'h00;
            tick_q <= 1'b0;
        end else if (div_q == TICK_LAST) begin
            div_q  <= 5'h00;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 5'h01;
            tick_q <= 1'b0;
        end
    end

    // stack config: straps caught on the first clock after reset release
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            strap_load_q <= 1'b1;
            stk2_q       <= 5'h00;
            stk3_q       <= 5'h00;
        end else if (strap_load_q) begin
            strap_load_q <= 1'b0;
            stk2_q       <= STACK_TWO_CONFIG_STRAPS;
            stk3_q       <= STACK_THREE_CONFIG_STRAPS;
        end else if (wr_en && sel_stk2) begin
            stk2_q <= PWDATA[`SDDT_STK_MSB:0];
        end else if (wr_en && sel_stk3) begin
            stk3_q <= PWDATA[`SDDT_STK_MSB:0];
        end
    end

    // delay registers and masks
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            rdrain_q  <= `SDDT_RDRAIN_RST;
            mdrain_q  <= `SDDT_MCDRAIN_RST;
            int_msk_q <= 3'h0;
        end else if (wr_en) begin
            case (PADDR)
                `SDDT_OFF_RDRAIN: begin
                    rdrain_q <= PWDATA[`SDDT_DLY_MSB:0];
                end
                `SDDT_OFF_MCDRAIN: begin
                    mdrain_q <= PWDATA[`SDDT_DLY_MSB:0];
                end
                `SDDT_OFF_INTMSK: begin
                    int_msk_q <= PWDATA[2:0];
                end
                default: ;
            endcase
        end
    end

    assign r_end = delay_ended(r_st_q, r_cnt_q, rdrain_q);
    assign m_end = delay_ended(m_st_q, m_cnt_q, mdrain_q);

    // reset drain timer
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            r_st_q           <= ST_IDLE;
            r_cnt_q          <= 17'h00000;
            RESET_DRAIN_DONE <= 1'b0;
        end else begin
            RESET_DRAIN_DONE <= 1'b0;
            case (r_st_q)
                ST_IDLE: begin
                    if (RESET_DRAIN_START) begin
                        r_st_q  <= ST_DRAIN;
                        r_cnt_q <= 17'h00000;
                    end
                end
                ST_DRAIN: begin
                    if (r_end) begin
                        r_st_q           <= ST_IDLE;
                        RESET_DRAIN_DONE <= 1'b1;
                    end else if (tick_q) begin
                        r_cnt_q <= r_cnt_q + 17'h00001;
                    end
                end
                default: r_st_q <= ST_IDLE;
            endcase
        end
    end

    // mode change timer: started flag first, done flag after the delay
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            m_st_q                   <= ST_IDLE;
            m_cnt_q                  <= 17'h00000;
            MODE_CHANGE_STARTED_FLAG <= 1'b0;
            MODE_CHANGE_DONE_FLAG    <= 1'b0;
        end else begin
            case (m_st_q)
                ST_IDLE: begin
                    if (MODE_CHANGE_REQ) begin
                        m_st_q                   <= ST_DRAIN;
                        m_cnt_q                  <= 17'h00000;
                        MODE_CHANGE_STARTED_FLAG <= 1'b1;
                        MODE_CHANGE_DONE_FLAG    <= 1'b0;
                    end
                end
                ST_DRAIN: begin
                    if (m_end) begin
                        m_st_q                   <= ST_IDLE;
                        MODE_CHANGE_STARTED_FLAG <= 1'b0;
                        MODE_CHANGE_DONE_FLAG    <= 1'b1;
                    end else if (tick_q) begin
                        m_cnt_q <= m_cnt_q + 17'h00001;
                    end
                end
                default: m_st_q <= ST_IDLE;
            endcase
        end
    end

    // single-cycle events of the two timers
    assign ev_rdone  = r_end;
    assign ev_mstart = (m_st_q == ST_IDLE) && MODE_CHANGE_REQ;
    assign ev_mdone  = m_end;
    assign sts_clr   = PWDATA[2:0];

    // sticky interrupt status, set wins over write-one-to-clear
    always @* begin
        ev_d = 3'h0;
        ev_d[`SDDT_INT_RDONE]  = ev_rdone;
        ev_d[`SDDT_INT_MSTART] = ev_mstart;
        ev_d[`SDDT_INT_MDONE]  = ev_mdone;
    end

    always @(posedge CLOCK) begin
        if (!RST_B) begin
            int_sts_q <= 3'h0;
        end else if (wr_en && sel_ists) begin
            int_sts_q <= (int_sts_q & ~sts_clr) | ev_d;
        end else begin
            int_sts_q <= int_sts_q | ev_d;
        end
    end

    assign IRQ = |(int_sts_q & int_msk_q);

    // read mux, unmapped reads return zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (PADDR)
            `SDDT_OFF_STK2: begin
                rdata_d[4:0] = stk2_q;
            end
            `SDDT_OFF_STK3: begin
                rdata_d[4:0] = stk3_q;
            end
            `SDDT_OFF_RDRAIN: begin
                rdata_d[15:0] = rdrain_q;
            end
            `SDDT_OFF_MCDRAIN: begin
                rdata_d[15:0] = mdrain_q;
            end
            `SDDT_OFF_INTSTS: begin
                rdata_d[2:0] = int_sts_q;
            end
            `SDDT_OFF_INTMSK: begin
                rdata_d[2:0] = int_msk_q;
            end
            `SDDT_OFF_STATE: begin
                rdata_d[3:0] = {MODE_CHANGE_DONE_FLAG,
                                MODE_CHANGE_STARTED_FLAG, m_st_q, r_st_q};
            end
            default:           rdata_d = 32'h0000_0000;
        endcase
    end

    // read data is caught in the setup cycle and held until the next read
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_en && !PENABLE) begin
            PRDATA <= rdata_d;
        end
    end

    // exported views of the registers and timer state
    assign STACK_TWO_LAYOUT_SELECT   = stk2_q;
    assign STACK_THREE_LAYOUT_SELECT = stk3_q;
    assign RESET_DRAIN_BUSY          = r_st_q;

endmodule // sddt_top

// [bench/sddt_properties.sv]
// port assertions of the drain delay timer block
// assumes binding to sddt_top with zero wait apb
`timescale 1ns/10ps
module sddt_properties (
    input wire        CLOCK,
    input wire        RST_B,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [4:0]  STACK_TWO_CONFIG_STRAPS,
    input wire [4:0]  STACK_TWO_LAYOUT_SELECT,
    input wire [4:0]  STACK_THREE_LAYOUT_SELECT,
    input wire        RESET_DRAIN_BUSY,
    input wire        RESET_DRAIN_DONE,
    input wire        MODE_CHANGE_STARTED_FLAG,
    input wire        MODE_CHANGE_DONE_FLAG,
    input wire        IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    wire        wr  = PSEL && PENABLE && PWRITE;
    wire [4:0]  wlo = PWDATA[4:0];
    reg  [15:0] dly_q;
    reg  [21:0] cnt_q;
    // shadow of the mode delay and cycles spent since the start flag
    always @(posedge CLOCK) begin
        if (!RST_B || (wr && PADDR == 12'h084))
            dly_q <= RST_B ? PWDATA[15:0] : 16'h03e8;
        cnt_q <= MODE_CHANGE_STARTED_FLAG ? cnt_q + 22'h1 : 22'h0;
    end
    property p_strap; $rose(RST_B) |=> STACK_TWO_LAYOUT_SELECT == $past(STACK_TWO_CONFIG_STRAPS); endproperty
    a_strap: assert property (p_strap) else $error("straps not loaded");
    property p_sel2; wr && PADDR == 12'h018 |=> STACK_TWO_LAYOUT_SELECT == $past(wlo); endproperty
    a_sel2: assert property (p_sel2) else $error("stack two select");
    property p_sel3; wr && PADDR == 12'h01c |=> STACK_THREE_LAYOUT_SELECT == $past(wlo); endproperty
    a_sel3: assert property (p_sel3) else $error("stack three select");
    property p_busy; $fell(RESET_DRAIN_BUSY) |-> RESET_DRAIN_DONE; endproperty
    a_busy: assert property (p_busy) else $error("busy ended without done");
    property p_pulse; RESET_DRAIN_DONE |=> !RESET_DRAIN_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
    property p_excl; !(MODE_CHANGE_STARTED_FLAG && MODE_CHANGE_DONE_FLAG); endproperty
    a_excl: assert property (p_excl) else $error("started and done together");
    property p_min; $rose(MODE_CHANGE_DONE_FLAG) |-> cnt_q + 1 >= dly_q * 25; endproperty
    a_min: assert property (p_min) else $error("mode change too short");
    property p_ack; MODE_CHANGE_DONE_FLAG |=> MODE_CHANGE_DONE_FLAG || MODE_CHANGE_STARTED_FLAG; endproperty
    a_ack: assert property (p_ack) else $error("done flag dropped");
    c_rdone: cover property (RESET_DRAIN_DONE);
    c_mdone: cover property ($rose(MODE_CHANGE_DONE_FLAG));
    c_irq: cover property (IRQ);
endmodule // sddt_properties
bind sddt_top sddt_properties sddt_chk_u (.*);

// [bench/tb_top.sv]
// self-checking bench of the drain delay timers over apb
// assumes sddt_top with zero wait apb and one 25 MHz clock
`timescale 1ns/10ps
module tb_top;
    reg         CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    reg  [11:0] PADDR = 0;
    reg  [31:0] PWDATA = 0;
    reg         RESET_DRAIN_START = 0, MODE_CHANGE_REQ = 0;
    reg  [4:0]  STACK_TWO_CONFIG_STRAPS = 5'h15, STACK_THREE_CONFIG_STRAPS = 5'h0a;
    wire [31:0] PRDATA;
    wire        PREADY, PSLVERR, RESET_DRAIN_BUSY, RESET_DRAIN_DONE, IRQ;
    wire        MODE_CHANGE_STARTED_FLAG, MODE_CHANGE_DONE_FLAG;
    wire [4:0]  STACK_TWO_LAYOUT_SELECT, STACK_THREE_LAYOUT_SELECT;
    int         n_errors = 0, comparisons = 0, cyc = 0, t;
    reg  [31:0] r;
    sddt_top dut_u (.*);
    initial forever #20 CLOCK = !CLOCK;
    task finish_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test;
        end
    end
    task chk(input [31:0] s, input [31:0] e, input string n);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1;
        do @(posedge CLOCK); while (PREADY !== 1);
        r = PRDATA;
        PSEL <= 0;
        PENABLE <= 0;
    endtask
    task rdc(input [11:0] a, input [31:0] e, input string n);
        apb(0, a, 0);
        chk(r, e, n);
    endtask
    // one start pulse, then the cycles until done are counted
    task drain(input m, input int lo, input int hi);
        @(posedge CLOCK);
        RESET_DRAIN_START <= !m;
        MODE_CHANGE_REQ <= m;
        @(posedge CLOCK);
        RESET_DRAIN_START <= 0;
        MODE_CHANGE_REQ <= 0;
        @(negedge CLOCK);
        chk(m ? MODE_CHANGE_STARTED_FLAG : RESET_DRAIN_BUSY, 1, "drain begun");
        t = 0;
        do begin
            @(negedge CLOCK);
            t++;
        end while ((m ? MODE_CHANGE_DONE_FLAG : RESET_DRAIN_DONE) !== 1 && t < 3000);
        chk(t >= lo && t <= hi, 1, "drain time");
    endtask
    initial begin
        repeat (12) @(posedge CLOCK);
        RST_B <= 1;
        repeat (2) @(posedge CLOCK);
        rdc(12'h080, 32'h0fa, "reset delay");
        rdc(12'h084, 32'h3e8, "mode delay");
        rdc(12'h018, 32'h15, "stack two");
        rdc(12'h01c, 32'h0a, "stack three");
        $display("test defaults done");
        apb(1, 12'h018, 32'hffffffea);
        apb(1, 12'h01c, 32'hfffffff5);
        rdc(12'h018, 32'h0a, "stack two");
        rdc(12'h01c, 32'h15, "stack three");
        chk(STACK_TWO_LAYOUT_SELECT, 5'h0a, "select two");
        chk(STACK_THREE_LAYOUT_SELECT, 5'h15, "select three");
        chk(PSLVERR, 0, "slave error");
        apb(1, 12'h080, 32'h10002);
        rdc(12'h080, 32'h2, "reset delay");
        apb(1, 12'h084, 32'hf0002);
        rdc(12'h084, 32'h2, "mode delay");
        rdc(12'h0a0, 32'h0, "unmapped");
        $display("test registers done");
        apb(1, 12'h094, 32'h7);
        drain(0, 50, 79);
        chk(RESET_DRAIN_BUSY, 0, "busy ended");
        chk(IRQ, 1, "irq");
        apb(1, 12'h090, 32'h1);
        @(negedge CLOCK);
        chk(IRQ, 0, "irq cleared");
        drain(1, 50, 79);
        rdc(12'h090, 32'h6, "status");
        rdc(12'h098, 32'h8, "state");
        apb(1, 12'h094, 32'h0);
        @(negedge CLOCK);
        chk(IRQ, 0, "irq masked");
        apb(1, 12'h084, 32'h0);
        drain(1, 1, 3);
        apb(1, 12'h080, 32'h0fa);
        rdc(12'h080, 32'h0fa, "reset delay restored");
        $display("test drains done");
        finish_test;
    end
endmodule // tb_top
